// ===== design/rct_pkg.sv
// Package holding register map, field layout and encodings of the reload and capture timer.
package rct_pkg;
  localparam logic [7:0] ADDR_CTRL_PRIMARY = 8'h98;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hA2;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hA3;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hA4;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hA5;
  localparam logic [7:0] ADDR_CTRL_SECONDARY = 8'hFF;

  localparam logic [7:0] RESET_CTRL_PRIMARY = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_FORCE_SELECT = 3'h0;
  localparam logic [2:0] RESET_CAPTURE_SELECT = 3'h1;

  // Primary control bit positions.
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_XCLK_HI = 1;
  localparam int BIT_XCLK_LO = 0;
  // Secondary control fields.
  localparam int BIT_FORCE_HI = 7;
  localparam int BIT_FORCE_LO = 5;
  localparam int BIT_SYNC_STATUS = 4;
  localparam int BIT_CAPSEL_HI = 2;
  localparam int BIT_CAPSEL_LO = 0;

  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [1:0] XCLK_SYSTEM = 2'h0;

  // Timer clocks to wait after a foreign wake-up.
  localparam logic [1:0] SYNC_WAIT_TICKS = 2'h3;
  localparam logic [1:0] SYNC_DONE = 2'h0;
  localparam logic [1:0] SYNC_STEP = 2'h1;

  localparam logic [2:0] FORCE_BUS_CLOCK = 3'h0;
  localparam logic [2:0] FORCE_UNIT_ZERO = 3'h1;
  localparam logic [2:0] FORCE_UNIT_ONE = 3'h2;
  localparam logic [2:0] FORCE_UNIT_TWO = 3'h3;
  localparam logic [2:0] FORCE_NONE = 3'h4;

  localparam logic [2:0] CAPSEL_PIN = 3'h0;
  localparam logic [2:0] CAPSEL_LFO = 3'h1;
  localparam logic [2:0] CAPSEL_COMPARATOR = 3'h2;
  localparam logic [2:0] CAPSEL_FRAME_START = 3'h3;

  // Order of the synchronised pin vector.
  localparam int PIN_EXT_CLK = 0;
  localparam int PIN_CAPTURE = 1;
  localparam int PIN_LFO = 2;
  localparam int PIN_COMPARATOR = 3;
  localparam int PIN_FRAME_START = 4;
  localparam int PIN_BUS_CLOCK = 5;
  localparam int PIN_COUNT = 6;
endpackage : rct_pkg

// ===== design/rct_sync2.sv
// Two-flip-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/1ns
module rct_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : rct_sync2

// ===== design/rct_timer.sv
// Reload and capture timer: counter, reload, capture, flags and special-function register port.
`timescale 1ns/1ns
module rct_timer
  import rct_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic ext_clock_pin,
  input wire logic capture_pin,
  input wire logic low_freq_oscillator,
  input wire logic comparator_zero_output,
  input wire logic usb_frame_start,
  input wire logic bus_clock_line,
  input wire logic bus_timeout_enable,
  input wire logic logic_unit_zero_output,
  input wire logic logic_unit_one_output,
  input wire logic logic_unit_two_output,
  input wire logic logic_unit_three_output,
  input wire logic foreign_wake,
  input wire logic timer_irq_enable,
  output logic timer_irq_req
);
  logic [PIN_COUNT-1:0] pin_sync;
  logic [7:0] src_now;
  logic [7:0] src_prev;
  logic ext_prev;
  logic high_overflow_flag;
  logic low_overflow_flag;
  logic low_byte_irq_enable;
  logic capture_enable;
  logic split_mode_enable;
  logic run_control;
  logic [1:0] ext_clock_select;
  logic [2:0] force_reload_select;
  logic [2:0] capture_source_select;
  logic reserved_bit;
  logic [1:0] sync_wait;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic tick;
  logic force_level;
  logic capture_event;
  logic next_set_low;
  logic next_set_high;
  logic [7:0] next_low;
  logic [7:0] next_high;
  logic wr_ctrl0;
  logic wr_ctrl1;

  rct_sync2 #(.WIDTH(PIN_COUNT)) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d({bus_clock_line, usb_frame_start, comparator_zero_output, low_freq_oscillator, capture_pin,
        ext_clock_pin}),
    .q(pin_sync)
  );

  assign wr_ctrl0 = sfr_wr && (sfr_addr == ADDR_CTRL_PRIMARY);
  assign wr_ctrl1 = sfr_wr && (sfr_addr == ADDR_CTRL_SECONDARY);

  // External source counts its rising edges; system clock ticks every cycle.
  // The external clock must stay below half the core rate or edges are lost.
  assign tick = (ext_clock_select == XCLK_SYSTEM) ? 1'b1 : (pin_sync[PIN_EXT_CLK] && !ext_prev);

  assign src_now = {logic_unit_three_output, logic_unit_two_output, logic_unit_one_output,
                    logic_unit_zero_output, pin_sync[PIN_FRAME_START], pin_sync[PIN_COMPARATOR],
                    pin_sync[PIN_LFO], pin_sync[PIN_CAPTURE]};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_prev <= '0;
      ext_prev <= 1'b0;
    end
    else
    begin
      src_prev <= src_now;
      ext_prev <= pin_sync[PIN_EXT_CLK];
    end
  end

  // Frame start is an event pulse, so its rising edge counts; all others capture on falling edges.
  always_comb
  begin
    if (capture_source_select == CAPSEL_FRAME_START)
    begin
      capture_event = src_now[capture_source_select] && !src_prev[capture_source_select];
    end
    else
    begin
      capture_event = !src_now[capture_source_select] && src_prev[capture_source_select];
    end
  end

  always_comb
  begin
    case (force_reload_select)
      FORCE_BUS_CLOCK: force_level = bus_timeout_enable && pin_sync[PIN_BUS_CLOCK];
      FORCE_UNIT_ZERO: force_level = logic_unit_zero_output;
      FORCE_UNIT_ONE: force_level = logic_unit_one_output;
      FORCE_UNIT_TWO: force_level = logic_unit_two_output;
      FORCE_NONE: force_level = 1'b0;
      default: force_level = 1'b0;
    endcase
  end

  // In capture mode the reload bytes hold captures, so overflow wraps to zero instead of reloading.
  always_comb
  begin
    next_low = count_low_byte;
    next_high = count_high_byte;
    next_set_low = 1'b0;
    next_set_high = 1'b0;
    if (tick)
    begin
      if (split_mode_enable)
      begin
        next_low = count_low_byte + BYTE_ONE;
        if (count_low_byte == BYTE_MAX)
        begin
          next_set_low = 1'b1;
          next_low = capture_enable ? BYTE_ZERO : reload_low_byte;
        end
        if (run_control)
        begin
          next_high = count_high_byte + BYTE_ONE;
          if (count_high_byte == BYTE_MAX)
          begin
            next_set_high = 1'b1;
            next_high = capture_enable ? BYTE_ZERO : reload_high_byte;
          end
        end
      end
      else if (run_control)
      begin
        {next_high, next_low} = {count_high_byte, count_low_byte} + {BYTE_ZERO, BYTE_ONE};
        next_set_low = (count_low_byte == BYTE_MAX);
        if ((count_high_byte == BYTE_MAX) && (count_low_byte == BYTE_MAX))
        begin
          next_set_high = 1'b1;
          next_low = capture_enable ? BYTE_ZERO : reload_low_byte;
          next_high = capture_enable ? BYTE_ZERO : reload_high_byte;
        end
      end
    end
    if (force_level && !capture_enable)
    begin
      next_low = reload_low_byte;
      next_high = reload_high_byte;
    end
  end

  // Firmware writes to the count bytes take precedence over counting.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_low_byte <= RESET_BYTE;
      count_high_byte <= RESET_BYTE;
    end
    else
    begin
      count_low_byte <= (sfr_wr && (sfr_addr == ADDR_COUNT_LOW)) ? sfr_wdata : next_low;
      count_high_byte <= (sfr_wr && (sfr_addr == ADDR_COUNT_HIGH)) ? sfr_wdata : next_high;
    end
  end

  // A capture in the same cycle as a firmware write to a reload byte wins.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reload_low_byte <= RESET_BYTE;
      reload_high_byte <= RESET_BYTE;
    end
    else if (capture_enable && capture_event)
    begin
      reload_low_byte <= count_low_byte;
      reload_high_byte <= count_high_byte;
    end
    else
    begin
      if (sfr_wr && (sfr_addr == ADDR_RELOAD_LOW))
      begin
        reload_low_byte <= sfr_wdata;
      end
      if (sfr_wr && (sfr_addr == ADDR_RELOAD_HIGH))
      begin
        reload_high_byte <= sfr_wdata;
      end
    end
  end

  // Hardware sets win over a firmware clear in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_overflow_flag <= RESET_CTRL_PRIMARY[BIT_HIGH_FLAG];
      low_overflow_flag <= RESET_CTRL_PRIMARY[BIT_LOW_FLAG];
    end
    else
    begin
      high_overflow_flag <= (wr_ctrl0 ? sfr_wdata[BIT_HIGH_FLAG] : high_overflow_flag) | next_set_high
                            | (capture_enable && capture_event);
      low_overflow_flag <= (wr_ctrl0 ? sfr_wdata[BIT_LOW_FLAG] : low_overflow_flag) | next_set_low;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_byte_irq_enable <= RESET_CTRL_PRIMARY[BIT_LOW_IRQ_EN];
      capture_enable <= RESET_CTRL_PRIMARY[BIT_CAPTURE_EN];
      split_mode_enable <= RESET_CTRL_PRIMARY[BIT_SPLIT];
      run_control <= RESET_CTRL_PRIMARY[BIT_RUN];
      ext_clock_select <= RESET_CTRL_PRIMARY[BIT_XCLK_HI:BIT_XCLK_LO];
    end
    else if (wr_ctrl0)
    begin
      low_byte_irq_enable <= sfr_wdata[BIT_LOW_IRQ_EN];
      capture_enable <= sfr_wdata[BIT_CAPTURE_EN];
      split_mode_enable <= sfr_wdata[BIT_SPLIT];
      run_control <= sfr_wdata[BIT_RUN];
      ext_clock_select <= sfr_wdata[BIT_XCLK_HI:BIT_XCLK_LO];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      force_reload_select <= RESET_FORCE_SELECT;
      capture_source_select <= RESET_CAPTURE_SELECT;
      reserved_bit <= 1'b0;
    end
    else if (wr_ctrl1)
    begin
      force_reload_select <= sfr_wdata[BIT_FORCE_HI:BIT_FORCE_LO];
      capture_source_select <= sfr_wdata[BIT_CAPSEL_HI:BIT_CAPSEL_LO];
      reserved_bit <= sfr_wdata[BIT_SYNC_STATUS - 1];
    end
  end

  // A foreign wake restarts the wait; each timer clock counts it down.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_wait <= SYNC_DONE;
    end
    else if (foreign_wake)
    begin
      sync_wait <= SYNC_WAIT_TICKS;
    end
    else if (tick && (sync_wait != SYNC_DONE))
    begin
      sync_wait <= sync_wait - SYNC_STEP;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sfr_rdata <= RESET_BYTE;
    end
    else if (sfr_rd)
    begin
      case (sfr_addr)
        ADDR_CTRL_PRIMARY: sfr_rdata <= {high_overflow_flag, low_overflow_flag, low_byte_irq_enable,
                                         capture_enable, split_mode_enable, run_control, ext_clock_select};
        ADDR_RELOAD_LOW: sfr_rdata <= reload_low_byte;
        ADDR_RELOAD_HIGH: sfr_rdata <= reload_high_byte;
        ADDR_COUNT_LOW: sfr_rdata <= count_low_byte;
        ADDR_COUNT_HIGH: sfr_rdata <= count_high_byte;
        ADDR_CTRL_SECONDARY: sfr_rdata <= {force_reload_select, (sync_wait != SYNC_DONE), reserved_bit,
                                           capture_source_select};
        default: sfr_rdata <= RESET_BYTE;
      endcase
    end
  end

  assign timer_irq_req = timer_irq_enable && (high_overflow_flag || (low_overflow_flag && low_byte_irq_enable));
endmodule : rct_timer

// ===== test/rct_timer_sva.sv
// Checker for the register port, counting, reload, interrupt and status behaviour of the timer.
`timescale 1ns/1ns
module rct_timer_chk
  import rct_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic logic_unit_zero_output,
  input wire logic foreign_wake,
  input wire logic timer_irq_enable,
  input wire logic timer_irq_req
);
  // Shadows of firmware-owned fields; the reload shadow goes stale once capture may rewrite it.
  logic [7:0] ctl;
  logic [8:0] rl;
  logic [2:0] fsel;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl <= RESET_CTRL_PRIMARY;
      rl <= 9'h000;
      fsel <= RESET_FORCE_SELECT;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == ADDR_CTRL_PRIMARY)
        ctl <= sfr_wdata;
      if (sfr_addr == ADDR_CTRL_PRIMARY && sfr_wdata[BIT_CAPTURE_EN])
        rl[8] <= 1'b0;
      if (sfr_addr == ADDR_RELOAD_LOW)
        rl <= {1'b1, sfr_wdata};
      if (sfr_addr == ADDR_CTRL_SECONDARY)
        fsel <= sfr_wdata[BIT_FORCE_HI:BIT_FORCE_LO];
    end
  end
  wire cap = ctl[BIT_CAPTURE_EN];
  wire sysclk = ctl[BIT_XCLK_HI:BIT_XCLK_LO] == XCLK_SYSTEM;
  wire runs = sysclk && !cap && fsel[2] && (ctl[BIT_RUN] || ctl[BIT_SPLIT]);
  wire halt = fsel[2] && !ctl[BIT_RUN];
  wire frc = fsel == FORCE_UNIT_ZERO && logic_unit_zero_output && !cap && ctl[BIT_RUN] && sysclk && !sfr_wr && rl[8];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_pair(a, ok);
    sfr_rd && sfr_addr == a && ok && !sfr_wr ##1 ok && !sfr_wr ##1 sfr_rd && sfr_addr == a && ok && !sfr_wr;
  endsequence
  sequence s_wr_rd(a);
    sfr_wr && sfr_addr == a && !cap ##1 !sfr_wr && !cap ##1 sfr_rd && sfr_addr == a && !sfr_wr && !cap;
  endsequence
  a_count_step: assert property (s_pair(ADDR_COUNT_LOW, runs) |=>
    $past(sfr_rdata, 2) >= 8'hFE || sfr_rdata == $past(sfr_rdata, 2) + 8'h02) else $error("low byte did not step");
  a_stop_hold: assert property (s_pair(ADDR_COUNT_HIGH, halt) |=> sfr_rdata == $past(sfr_rdata, 2))
    else $error("high byte moved while stopped");
  a_reload_back: assert property (s_wr_rd(ADDR_RELOAD_LOW) |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("reload byte lost");
  a_select_back: assert property (s_wr_rd(ADDR_CTRL_SECONDARY) |=>
    {sfr_rdata[7:5], sfr_rdata[3:0]} == {$past(sfr_wdata[7:5], 3), $past(sfr_wdata[3:0], 3)})
    else $error("select lost");
  a_wake_status: assert property (foreign_wake ##2 sfr_rd && sfr_addr == ADDR_CTRL_SECONDARY |=>
    sfr_rdata[BIT_SYNC_STATUS]) else $error("sync status not pending");
  a_sync_clear: assert property ((!foreign_wake && sysclk)[*4] ##1
    sfr_rd && sfr_addr == ADDR_CTRL_SECONDARY |=> !sfr_rdata[BIT_SYNC_STATUS]) else $error("sync status stuck");
  a_irq_gate: assert property (!timer_irq_enable |-> !timer_irq_req) else $error("request while disabled");
  a_flag_irq: assert property (sfr_wr && sfr_addr == ADDR_CTRL_PRIMARY && sfr_wdata[BIT_HIGH_FLAG]
    ##1 timer_irq_enable |-> timer_irq_req) else $error("flag gave no request");
  a_force_reload: assert property (frc ##1 frc && sfr_rd && sfr_addr == ADDR_COUNT_LOW |=>
    sfr_rdata == rl[7:0]) else $error("forced reload missing");
endmodule : rct_timer_chk

bind rct_timer rct_timer_chk u_rct_timer_chk (.core_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
  .logic_unit_zero_output, .foreign_wake, .timer_irq_enable, .timer_irq_req);

// ===== test/tb_rct_timer.sv
// Self-checking bench for the reload and capture timer.
`timescale 1ns/1ns
module tb_rct_timer;
  import rct_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic [7:0] src = 8'h00;
  logic bus_line = 1'b0;
  logic bus_en = 1'b0;
  logic wake = 1'b0;
  logic irq_en = 1'b0;
  logic irq;
  logic [7:0] d;
  logic [7:0] d0;
  logic ext_pin = 1'b0;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [7:0] ra[7] = '{8'h98, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hFF, 8'h10};
  logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  rct_timer u_rct_timer (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .ext_clock_pin(ext_pin), .capture_pin(src[0]),
    .low_freq_oscillator(src[1]), .comparator_zero_output(src[2]), .usb_frame_start(src[3]),
    .bus_clock_line(bus_line), .bus_timeout_enable(bus_en), .logic_unit_zero_output(src[4]),
    .logic_unit_one_output(src[5]), .logic_unit_two_output(src[6]), .logic_unit_three_output(src[7]),
    .foreign_wake(wake), .timer_irq_enable(irq_en), .timer_irq_req(irq));
  always #2 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask : wr
  // Read data is registered at the taking edge, so it is settled by the following falling edge.
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask : rc
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  initial
  begin
    #40000;
    n_mismatch++;
    test_done();
  end
  initial
  begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    foreach (ra[i])
      rc(ra[i], rv[i]);
    $display("Test reset values done");
    irq_en = 1'b1;
    wr(ADDR_RELOAD_LOW, 8'h34);
    rc(ADDR_RELOAD_LOW, 8'h34);
    wr(ADDR_RELOAD_HIGH, 8'h12);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_COUNT_LOW, 8'hFD);
    wr(ADDR_CTRL_SECONDARY, 8'h81);
    rc(ADDR_CTRL_SECONDARY, 8'h81);
    wr(ADDR_CTRL_PRIMARY, 8'h04);
    repeat (4) @(negedge core_clk);
    rc(ADDR_COUNT_HIGH, 8'h12);
    rc(ADDR_CTRL_PRIMARY, 8'hC4);
    chk(irq, 1'b1);
    wr(ADDR_CTRL_PRIMARY, 8'h04);
    chk(irq, 1'b0);
    $display("Test wide overflow done");
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_CTRL_SECONDARY, {k[2:0], 5'h01});
      if (k == 0)
        {bus_en, bus_line} = 2'b11;
      else
        src[3 + k] = 1'b1;
      repeat (4) @(negedge core_clk);
      rc(ADDR_COUNT_LOW, 8'h34);
      src = 8'h00;
      {bus_en, bus_line} = 2'b00;
    end
    // With forcing switched off, a high unit output must not hold the count.
    wr(ADDR_CTRL_SECONDARY, 8'h81);
    src[4] = 1'b1;
    rd(ADDR_COUNT_LOW);
    d0 = d;
    rd(ADDR_COUNT_LOW);
    chk(d - d0, 8'h02);
    $display("Test forced reload done");
    wr(ADDR_CTRL_PRIMARY, 8'h28);
    wr(ADDR_RELOAD_LOW, 8'hF0);
    wr(ADDR_COUNT_HIGH, 8'h55);
    wr(ADDR_COUNT_LOW, 8'hFE);
    repeat (4) @(negedge core_clk);
    rc(ADDR_CTRL_PRIMARY, 8'h68);
    chk(irq, 1'b1);
    rc(ADDR_COUNT_HIGH, 8'h55);
    rc(ADDR_COUNT_HIGH, 8'h55);
    rd(ADDR_COUNT_LOW);
    chk(d >= 8'hF0, 1'b1);
    $display("Test split mode done");
    wake = 1'b1;
    @(negedge core_clk);
    wake = 1'b0;
    rc(ADDR_CTRL_SECONDARY, 8'h91);
    repeat (4) @(negedge core_clk);
    rc(ADDR_CTRL_SECONDARY, 8'h81);
    $display("Test wake status done");
    wr(ADDR_CTRL_PRIMARY, 8'h10);
    src = 8'hF7;
    for (int k = 0; k < 8; k++)
    begin
      wr(ADDR_COUNT_LOW, k[7:0]);
      wr(ADDR_COUNT_HIGH, 8'hC0);
      wr(ADDR_CTRL_SECONDARY, {5'h10, k[2:0]});
      src[k] = ~src[k];
      repeat (6) @(negedge core_clk);
      src[k] = ~src[k];
      rc(ADDR_RELOAD_LOW, k[7:0]);
      rc(ADDR_RELOAD_HIGH, 8'hC0);
      rc(ADDR_CTRL_PRIMARY, 8'h90);
      chk(irq, 1'b1);
      wr(ADDR_CTRL_PRIMARY, 8'h10);
    end
    $display("Test capture sources done");
    // On the external clock the wake wait only drains on pin edges, so status stays pending meanwhile.
    wr(ADDR_CTRL_PRIMARY, 8'h85);
    chk(irq, 1'b1);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h00);
    wake = 1'b1;
    @(negedge core_clk);
    wake = 1'b0;
    repeat (6) @(negedge core_clk);
    rc(ADDR_CTRL_SECONDARY, 8'h97);
    repeat (5)
    begin
      ext_pin = 1'b1;
      repeat (4) @(negedge core_clk);
      ext_pin = 1'b0;
      repeat (4) @(negedge core_clk);
    end
    rc(ADDR_CTRL_SECONDARY, 8'h87);
    rc(ADDR_COUNT_LOW, 8'h05);
    $display("Test external clock done");
    test_done();
  end
endmodule : tb_rct_timer
